// ### src/phy_fic_pkg.sv
package phy_fic_pkg;

   // Register port widths
   localparam int ADDR_W = 6;
   localparam int DATA_W = 8;

   // Register offsets
   localparam logic [ADDR_W-1:0] ADDR_FUNC_CTRL = 6'h04;
   localparam logic [ADDR_W-1:0] ADDR_FC_SET = 6'h05;
   localparam logic [ADDR_W-1:0] ADDR_FC_CLR = 6'h06;
   localparam logic [ADDR_W-1:0] ADDR_IFC_CTRL = 6'h07;

   // Function control layout
   localparam int FC_RSVD_BIT = 7;
   localparam int FC_LP_BIT = 6;
   localparam int FC_RESTART_BIT = 5;
   localparam int FC_DRIVE_HI = 4;
   localparam int FC_DRIVE_LO = 3;
   localparam int FC_TERM_BIT = 2;
   localparam int FC_SPEED_HI = 1;
   localparam int FC_SPEED_LO = 0;
   localparam logic [DATA_W-1:0] FC_RESET = 8'h41;
   localparam logic [DATA_W-1:0] FC_WMASK = 8'h7f;

   // Interface control layout, only the upper three bits live here
   localparam int IFC_GUARD_OFF_BIT = 7;
   localparam int IFC_UNQUAL_BIT = 6;
   localparam int IFC_INVERT_BIT = 5;
   localparam logic [DATA_W-1:0] IFC_RESET = 8'h00;
   localparam logic [DATA_W-1:0] IFC_WMASK = 8'he0;

   // Answer to an unmapped read
   localparam logic [DATA_W-1:0] RDATA_NONE = 8'h00;

   // Transceiver restart timing
   localparam int CLK_PERIOD_NS = 25;
   localparam int RESTART_NS = 250;
   localparam int RESTART_CYCLES = (RESTART_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 8;
   localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
   localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
   localparam logic [CNT_W-1:0] RESTART_LOAD = CNT_W'(RESTART_CYCLES - 1);

   // Register access request from the link side
   typedef struct packed {
      logic wr;
      logic rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } reg_req_t;

   // Register read answer
   typedef struct packed {
      logic valid;
      logic [DATA_W-1:0] data;
   } reg_rsp_t;

   // Restart sequencer states
   typedef enum logic [3:0] {
      SEQ_IDLE = 4'h1,
      SEQ_RESTART = 4'h2,
      SEQ_GAP = 4'h4,
      SEQ_UPDATE = 4'h8
   } seq_t;

endpackage : phy_fic_pkg

// ### src/vbus_indicator_qual.sv
`timescale 1ns/10ps
module vbus_indicator_qual (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset,
   // Pin and comparator
   input wire logic external_supply_indicator_in,
   input wire logic vbus_valid_cmp,
   // Configuration
   input wire logic indicator_invert,
   input wire logic indicator_unqualified,
   // Result
   output logic vbus_state
);

   typedef struct packed {
      logic [2:0] sync;
      logic stable;
      logic vbus;
   } qual_state_t;

   qual_state_t s_ff;
   qual_state_t nxt_s;

   // Pin passes three flops; a change counts only once the last two agree
   always_comb begin
      nxt_s = s_ff;
      nxt_s.sync = {s_ff.sync[1:0], external_supply_indicator_in};
      if (s_ff.sync[1] == s_ff.sync[2]) begin
         nxt_s.stable = s_ff.sync[2];
      end
      if (indicator_unqualified) begin
         nxt_s.vbus = s_ff.stable ^ indicator_invert; // R6 R7
      end else begin
         nxt_s.vbus = (s_ff.stable ^ indicator_invert) & vbus_valid_cmp; // R6 R7
      end
   end

   // State register
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign vbus_state = s_ff.vbus;

endmodule : vbus_indicator_qual

// ### src/phy_function_interface_ctrl_regs.sv
`timescale 1ns/10ps
// What this block does
// R1 - Set alias reads byte, ones set bits
// R2 - Clear alias reads byte, ones clear bits
// R3 - Aliases share function control bit layout
// R4 - Interface control read-write at offset seven
// R5 - Bit seven disables pin guard, resets zero
// R6 - Bit six bypasses comparator qualification
// R7 - Bit five inverts external supply indicator
// R8 - Function control byte stored at offset four
// R9 - Restart: DIR high, clear, RX CMD update
// R10 - Low power exit sets request bit again
// R11 - Reserved bit seven never written, reads zero
module phy_function_interface_ctrl_regs (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset,
   // Register access
   input wire phy_fic_pkg::reg_req_t reg_req,
   output phy_fic_pkg::reg_rsp_t reg_rsp,
   // Transceiver events and pins
   input wire logic low_power_exit,
   input wire logic external_supply_indicator_in,
   input wire logic vbus_valid_cmp,
   // Function settings
   output logic low_power_request_n,
   output logic transceiver_restart,
   output logic [1:0] line_drive_style,
   output logic termination_choice,
   output logic [1:0] speed_choice,
   // Interface features
   output logic port_guard_off,
   output logic vbus_state,
   // Bus turnaround and status update
   output logic dir,
   output logic rxcmd_update
);

   localparam int RST_LEN = phy_fic_pkg::RESTART_CYCLES;

   typedef struct packed {
      phy_fic_pkg::seq_t seq;
      logic [phy_fic_pkg::CNT_W-1:0] cnt;
      logic [phy_fic_pkg::DATA_W-1:0] fc;
      logic [phy_fic_pkg::DATA_W-1:0] ifc;
      phy_fic_pkg::reg_rsp_t rsp;
      logic dir;
      logic core_reset;
      logic rxcmd_upd;
   } regs_state_t;

   regs_state_t s_ff;
   regs_state_t nxt_s;
   logic wr_fc;
   logic wr_set;
   logic wr_clr;
   logic wr_ifc;
   logic sw_set_restart;

   // Any of the three function control addresses
   function automatic logic is_fc_addr(input logic [phy_fic_pkg::ADDR_W-1:0] a);
      is_fc_addr = (a == phy_fic_pkg::ADDR_FUNC_CTRL) || (a == phy_fic_pkg::ADDR_FC_SET) ||
                   (a == phy_fic_pkg::ADDR_FC_CLR);
   endfunction : is_fc_addr

   // Write decode
   assign wr_fc = reg_req.wr && (reg_req.addr == phy_fic_pkg::ADDR_FUNC_CTRL);
   assign wr_set = reg_req.wr && (reg_req.addr == phy_fic_pkg::ADDR_FC_SET);
   assign wr_clr = reg_req.wr && (reg_req.addr == phy_fic_pkg::ADDR_FC_CLR);
   assign wr_ifc = reg_req.wr && (reg_req.addr == phy_fic_pkg::ADDR_IFC_CTRL);
   assign sw_set_restart = (wr_fc || wr_set) && reg_req.wdata[phy_fic_pkg::FC_RESTART_BIT];

   // Register writes, read answer and restart sequencing
   always_comb begin
      nxt_s = s_ff;
      nxt_s.rxcmd_upd = 1'b0;
      // Software writes go first so that low power exit below wins; a software restart set beats the self clear
      if (wr_fc) begin
         nxt_s.fc = reg_req.wdata & phy_fic_pkg::FC_WMASK; // R8 R11
      end
      if (wr_set) begin
         nxt_s.fc = s_ff.fc | (reg_req.wdata & phy_fic_pkg::FC_WMASK); // R1 R3 R11
      end
      if (wr_clr) begin
         nxt_s.fc = s_ff.fc & ~(reg_req.wdata & phy_fic_pkg::FC_WMASK); // R2 R3
      end
      if (wr_ifc) begin
         nxt_s.ifc = reg_req.wdata & phy_fic_pkg::IFC_WMASK; // R4 R5
      end
      // Aliases read the shared byte; old value if written in the same cycle
      nxt_s.rsp.valid = reg_req.rd;
      if (!reg_req.rd) begin
         nxt_s.rsp.data = s_ff.rsp.data;
      end else if (is_fc_addr(reg_req.addr)) begin
         nxt_s.rsp.data = s_ff.fc; // R1 R2 R8
      end else if (reg_req.addr == phy_fic_pkg::ADDR_IFC_CTRL) begin
         nxt_s.rsp.data = s_ff.ifc; // R4
      end else begin
         nxt_s.rsp.data = phy_fic_pkg::RDATA_NONE;
      end
      // Restart sequencer; registers are left alone apart from the bit
      case (s_ff.seq)
         phy_fic_pkg::SEQ_IDLE: begin
            if (s_ff.fc[phy_fic_pkg::FC_RESTART_BIT]) begin
               nxt_s.seq = phy_fic_pkg::SEQ_RESTART; // R9
               nxt_s.cnt = phy_fic_pkg::RESTART_LOAD;
               nxt_s.dir = 1'b1;
               nxt_s.core_reset = 1'b1;
            end
         end
         phy_fic_pkg::SEQ_RESTART: begin
            if (s_ff.cnt != phy_fic_pkg::CNT_ZERO) begin
               nxt_s.cnt = s_ff.cnt - phy_fic_pkg::CNT_ONE;
            end else begin
               nxt_s.seq = phy_fic_pkg::SEQ_GAP; // R9
               nxt_s.dir = 1'b0;
               nxt_s.core_reset = 1'b0;
               // A software set in this same cycle wins over the self clear
               if (!sw_set_restart) begin
                  nxt_s.fc[phy_fic_pkg::FC_RESTART_BIT] = 1'b0; // R9
               end
            end
         end
         phy_fic_pkg::SEQ_GAP: begin
            nxt_s.seq = phy_fic_pkg::SEQ_UPDATE; // R9
            nxt_s.dir = 1'b1;
            nxt_s.rxcmd_upd = 1'b1;
         end
         phy_fic_pkg::SEQ_UPDATE: begin
            nxt_s.seq = phy_fic_pkg::SEQ_IDLE;
            nxt_s.dir = 1'b0;
         end
         default: begin
            nxt_s.seq = phy_fic_pkg::SEQ_IDLE;
            nxt_s.dir = 1'b0;
            nxt_s.core_reset = 1'b0;
         end
      endcase
      // Leaving low power always restores the request bit, over a clear
      if (low_power_exit) begin
         nxt_s.fc[phy_fic_pkg::FC_LP_BIT] = 1'b1; // R10
      end
   end

   // State register
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         s_ff.seq <= phy_fic_pkg::SEQ_IDLE;
         s_ff.cnt <= phy_fic_pkg::CNT_ZERO;
         s_ff.fc <= phy_fic_pkg::FC_RESET;
         s_ff.ifc <= phy_fic_pkg::IFC_RESET; // R5
         s_ff.rsp <= '0;
         s_ff.dir <= 1'b0;
         s_ff.core_reset <= 1'b0;
         s_ff.rxcmd_upd <= 1'b0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   // Supply indicator path, registered inside
   vbus_indicator_qual u_vbus_qual (
      .mclk(mclk),
      .reset(reset),
      .external_supply_indicator_in(external_supply_indicator_in),
      .vbus_valid_cmp(vbus_valid_cmp),
      .indicator_invert(s_ff.ifc[phy_fic_pkg::IFC_INVERT_BIT]), // R7
      .indicator_unqualified(s_ff.ifc[phy_fic_pkg::IFC_UNQUAL_BIT]), // R6
      .vbus_state(vbus_state)
   );

   // Outputs straight from state flops
   assign reg_rsp = s_ff.rsp;
   assign low_power_request_n = s_ff.fc[phy_fic_pkg::FC_LP_BIT];
   assign transceiver_restart = s_ff.core_reset;
   assign line_drive_style = s_ff.fc[phy_fic_pkg::FC_DRIVE_HI:phy_fic_pkg::FC_DRIVE_LO];
   assign termination_choice = s_ff.fc[phy_fic_pkg::FC_TERM_BIT];
   assign speed_choice = s_ff.fc[phy_fic_pkg::FC_SPEED_HI:phy_fic_pkg::FC_SPEED_LO];
   assign port_guard_off = s_ff.ifc[phy_fic_pkg::IFC_GUARD_OFF_BIT]; // R5
   assign dir = s_ff.dir;
   assign rxcmd_update = s_ff.rxcmd_upd;

   // Set alias: every written one except reserved bit seven is present afterwards
   a_set_alias_sets: assert property (@(posedge mclk) disable iff (reset) // R1
      wr_set |=> ((s_ff.fc & $past(reg_req.wdata) & phy_fic_pkg::FC_WMASK) ==
                  ($past(reg_req.wdata) & phy_fic_pkg::FC_WMASK)))
      else $error("set alias left a bit clear");

   // Clear alias: written ones are gone unless low power exit restores bit six
   a_clear_alias_clears: assert property (@(posedge mclk) disable iff (reset) // R2
      wr_clr && !low_power_exit |=>
         ((s_ff.fc & $past(reg_req.wdata)) == 8'h00))
      else $error("clear alias left a bit set");

   // Reserved bit always zero
   a_rsvd_reads_zero: assert property (@(posedge mclk) disable iff (reset) // R11
      reg_rsp.valid |-> (!s_ff.fc[phy_fic_pkg::FC_RSVD_BIT] &&
                          !reg_rsp.data[phy_fic_pkg::FC_RSVD_BIT] ||
                          $past(reg_req.addr) == phy_fic_pkg::ADDR_IFC_CTRL))
      else $error("reserved bit seen set");

   // Aliases and base read the same stored byte one cycle later
   a_alias_read_data: assert property (@(posedge mclk) disable iff (reset) // R3
      reg_req.rd && is_fc_addr(reg_req.addr) |=> reg_rsp.valid &&
         (reg_rsp.data == $past(s_ff.fc)))
      else $error("function control read mismatch");

   // Interface control write stores upper bits only
   a_ifc_write: assert property (@(posedge mclk) disable iff (reset) // R4
      wr_ifc |=> (s_ff.ifc == ($past(reg_req.wdata) & phy_fic_pkg::IFC_WMASK)) &&
         (port_guard_off == $past(reg_req.wdata[phy_fic_pkg::IFC_GUARD_OFF_BIT])))
      else $error("interface control write lost");

   // Restart: DIR high at the start, gap RST_LEN cycles later, then one update cycle
   a_restart_sequence: assert property (@(posedge mclk) disable iff (reset) // R9
      $rose(transceiver_restart) |-> dir ##RST_LEN (!dir && !transceiver_restart)
         ##1 (dir && rxcmd_update) ##1 (!dir && !rxcmd_update))
      else $error("restart sequence out of step");

   // Restart bit is cleared by the device at completion
   a_restart_self_clear: assert property (@(posedge mclk) disable iff (reset) // R9
      $fell(transceiver_restart) && !$past(sw_set_restart) |->
         !s_ff.fc[phy_fic_pkg::FC_RESTART_BIT])
      else $error("restart bit not cleared");

   // Low power exit forces the request bit high
   a_lp_exit_sets: assert property (@(posedge mclk) disable iff (reset) // R10
      low_power_exit |=> low_power_request_n)
      else $error("low power request not restored");

endmodule : phy_function_interface_ctrl_regs

// ### tb/link_ctrl_model.sv
`timescale 1ns/10ps
// Link controller side of the register port, one request at a time
module link_ctrl_model (
   // Clock
   input wire logic mclk,
   // Register port
   output phy_fic_pkg::reg_req_t reg_req,
   input wire phy_fic_pkg::reg_rsp_t reg_rsp
);
   initial reg_req = '0;

   // A strobe is taken at the next edge; released strobes go low, released address and data lines show the inverse of the last value
   task automatic xfer(input logic w, input logic [5:0] a, input logic [7:0] d,
         output logic [7:0] q);
      int n;
      q = 'x;
      @(posedge mclk);
      reg_req <= '{wr: w, rd: ~w, addr: a, wdata: d};
      @(posedge mclk);
      reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
      // Answer is looked for in the cycle after the taking edge, bounded
      for (n = 0; n < 4 && !w; n++) begin
         #1;
         if (reg_rsp.valid === 1'b1) begin
            q = reg_rsp.data;
            break;
         end
         @(posedge mclk);
      end
   endtask : xfer
endmodule : link_ctrl_model

// ### tb/phy_function_interface_ctrl_regs_bench.sv
`timescale 1ns/10ps
// Self-checking bench for the function and interface control registers
module phy_function_interface_ctrl_regs_bench;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic low_power_exit = 1'b0;
   logic ext_in = 1'b0;
   logic cmp = 1'b0;
   phy_fic_pkg::reg_req_t reg_req;
   phy_fic_pkg::reg_rsp_t reg_rsp;
   logic lp_n, rst_run, term, guard, vbus, dir, rxu;
   logic [1:0] drive, speed;
   logic [7:0] fc, ifc, rd, d;
   logic [5:0] a, b;
   int err_count = 0;
   int checks_done = 0;
   int i, n;

   always #12.5 mclk = ~mclk;

   phy_function_interface_ctrl_regs u_phy_function_interface_ctrl_regs (
      .mclk(mclk), .reset(reset), .reg_req(reg_req), .reg_rsp(reg_rsp),
      .low_power_exit(low_power_exit), .external_supply_indicator_in(ext_in),
      .vbus_valid_cmp(cmp), .low_power_request_n(lp_n), .transceiver_restart(rst_run),
      .line_drive_style(drive), .termination_choice(term), .speed_choice(speed),
      .port_guard_off(guard), .vbus_state(vbus), .dir(dir), .rxcmd_update(rxu));

   link_ctrl_model u_link_ctrl_model (.mclk(mclk), .reg_req(reg_req), .reg_rsp(reg_rsp));

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic close_out;
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : close_out

   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      u_link_ctrl_model.xfer(1'b1, a, d, rd);
   endtask : wr

   task automatic rdc(input logic [5:0] a, input logic [7:0] exp);
      u_link_ctrl_model.xfer(1'b0, a, 8'h00, rd);
      check("read data", rd, exp);
   endtask : rdc

   // Outputs mirror the expected bytes; bit 7 of function control must stay zero
   task automatic out_chk;
      #1;
      check("function outputs", {1'b0, lp_n, rst_run, drive, term, speed}, fc);
      check("guard off", guard, ifc[7]);
      check("dir idle", dir, 1'b0);
   endtask : out_chk

   // Expected function control byte after a write to any offset
   function automatic logic [7:0] fc_next(input logic [7:0] c, input logic [5:0] a,
         input logic [7:0] d);
      case (a)
         6'h04: return d & 8'h7f;
         6'h05: return (c | d) & 8'h7f;
         6'h06: return c & ~d;
         default: return c;
      endcase
   endfunction : fc_next

   // Watchdog, far beyond the few hundred cycles the tests need
   initial begin
      #100us;
      err_count++;
      $display("watchdog expired");
      close_out();
   end

   initial begin
      i = $urandom(88384);
      fc = 8'h41;
      ifc = 8'h00;
      repeat (5) @(posedge mclk);
      reset <= 1'b0;
      rdc(6'h04, 8'h41);
      rdc(6'h05, 8'h41);
      rdc(6'h06, 8'h41);
      rdc(6'h07, 8'h00);
      rdc(6'h08, 8'h00);
      out_chk();
      $display("test reset done");
      // Random writes over all offsets plus one unmapped; restart bit kept out here
      for (i = 0; i < 40; i++) begin
         a = (i < 2) ? 6'h05 : 6'h04 + 6'($urandom_range(0, 4));
         d = (i < 2) ? 8'hdf : 8'($urandom) & 8'hdf;
         wr(a, d);
         fc = fc_next(fc, a, d);
         if (a == 6'h07) ifc = d & 8'he0;
         b = 6'h04 + 6'($urandom_range(0, 3));
         rdc(b, (b == 6'h07) ? ifc : fc);
         out_chk();
      end
      $display("test random access done");
      // Restart runs its full length, clears itself, then signals a status update
      wr(6'h05, 8'h20);
      for (n = 0; dir !== 1'b1 && n < 8; n++) begin
         @(posedge mclk);
         #1;
      end
      for (n = 0; rst_run === 1'b1 && n < 20; n++) begin
         @(posedge mclk);
         #1;
      end
      check("restart cycles", 8'(n), 8'(phy_fic_pkg::RESTART_CYCLES));
      check("dir gap", dir, 1'b0);
      @(posedge mclk);
      #1;
      check("dir update", {dir, rxu}, 8'h03);
      @(posedge mclk);
      #1;
      check("dir released", {dir, rxu}, 8'h00);
      rdc(6'h04, fc);
      rdc(6'h07, ifc);
      $display("test restart done");
      // Low power exit sets the request bit back after a clear
      wr(6'h06, 8'h40);
      fc[6] = 1'b0;
      out_chk();
      @(posedge mclk);
      low_power_exit <= 1'b1;
      @(posedge mclk);
      low_power_exit <= 1'b0;
      fc[6] = 1'b1;
      out_chk();
      // Exit and a clear of bit six taken on one edge: the set must win
      fork
         wr(6'h06, 8'h40);
         begin
            @(posedge mclk);
            low_power_exit <= 1'b1;
            @(posedge mclk);
            low_power_exit <= 1'b0;
         end
      join
      out_chk();
      $display("test low power done");
      // Every mix of pin, comparator, invert and pass-through
      for (i = 0; i < 16; i++) begin
         ifc = {i[3], i[1], i[0], 5'h00};
         wr(6'h07, ifc | 8'h1f);
         ext_in <= i[2];
         cmp <= i[3];
         repeat (8) @(posedge mclk);
         #1;
         check("vbus state", vbus, (i[2] ^ i[0]) & (i[1] | i[3]));
         out_chk();
      end
      $display("test indicator done");
      // Reset in mid-run brings every register back to its reset value
      @(posedge mclk);
      reset <= 1'b1;
      repeat (2) @(posedge mclk);
      reset <= 1'b0;
      fc = 8'h41;
      ifc = 8'h00;
      rdc(6'h04, fc);
      rdc(6'h07, ifc);
      out_chk();
      $display("test mid reset done");
      close_out();
   end
endmodule : phy_function_interface_ctrl_regs_bench
